// File: verilog/acfg_pkg.sv
// Package with register map, field layout and bus codes of the setup bank
package acfg_pkg;
	localparam int          ACFG_NUM_SETUPS   = 8;
	localparam int          ACFG_DATA_W       = 32;
	localparam int          ACFG_ADDR_W       = 8;
	localparam int          ACFG_SETUP_W      = 16;
	// Register indices; byte address is four times the index
	localparam logic [5:0]  ACFG_IDX_SETUP0   = 6'h19;
	localparam logic [5:0]  ACFG_IDX_SETUP7   = 6'h20;
	localparam logic [5:0]  ACFG_IDX_ACTIVE   = 6'h30;
	localparam logic [15:0] ACFG_SETUP_RST    = 16'h0000;
	// Setup word fields
	localparam int          ACFG_EXC1_MSB     = 15;
	localparam int          ACFG_EXC1_LSB     = 13;
	localparam int          ACFG_EXC0_MSB     = 12;
	localparam int          ACFG_EXC0_LSB     = 10;
	localparam int          ACFG_BURN_MSB     = 9;
	localparam int          ACFG_BURN_LSB     = 8;
	localparam int          ACFG_REFP_BIT     = 7;
	localparam int          ACFG_REFN_BIT     = 6;
	localparam int          ACFG_REFSEL_MSB   = 5;
	localparam int          ACFG_REFSEL_LSB   = 4;
	localparam int          ACFG_GAIN_MSB     = 3;
	localparam int          ACFG_GAIN_LSB     = 1;
	localparam int          ACFG_BYP_BIT      = 0;
	localparam logic [2:0]  ACFG_GAIN_UNITY   = 3'h0;
	// Active setup status fields
	localparam int          ACFG_ACT_SEL_MSB  = 2;
	localparam int          ACFG_ACT_VALID    = 8;
	// Bus responses
	localparam logic [1:0]  ACFG_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  ACFG_RESP_SLVERR  = 2'h2;
endpackage

// File: verilog/acfg_setup_fields.sv
// Splits one setup word into front-end control fields
`timescale 1ns/1ps
module acfg_setup_fields
	import acfg_pkg::*;
(
	input  wire logic [15:0] setup_word,
	output logic      [2:0]  excite_src1_level,
	output logic      [2:0]  excite_src0_level,
	output logic      [1:0]  burnout_level,
	output logic             ref_pos_buffer_on,
	output logic             ref_neg_buffer_on,
	output logic      [1:0]  ref_sel,
	output logic      [2:0]  amp_gain_code,
	output logic             amp_bypass
);
	always_comb begin
		excite_src1_level = setup_word[ACFG_EXC1_MSB:ACFG_EXC1_LSB];
		excite_src0_level = setup_word[ACFG_EXC0_MSB:ACFG_EXC0_LSB];
		burnout_level     = setup_word[ACFG_BURN_MSB:ACFG_BURN_LSB];
		ref_pos_buffer_on = setup_word[ACFG_REFP_BIT];
		ref_neg_buffer_on = setup_word[ACFG_REFN_BIT];
		ref_sel           = setup_word[ACFG_REFSEL_MSB:ACFG_REFSEL_LSB];
		amp_bypass        = setup_word[ACFG_BYP_BIT];
		// Bypass forces unity gain
		amp_gain_code     = amp_bypass ? ACFG_GAIN_UNITY
			: setup_word[ACFG_GAIN_MSB:ACFG_GAIN_LSB];
	end
endmodule

// File: verilog/acfg_bank.sv
// Setup configuration bank with AXI4-Lite access and per-conversion latch
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module acfg_bank
	import acfg_pkg::*;
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [ACFG_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [ACFG_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic      [1:0]             s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [ACFG_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic      [ACFG_DATA_W-1:0] s_axi_rdata,
	output logic      [1:0]             s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic                   conv_start,
	input  wire logic [2:0]             conv_setup_sel,
	output logic      [2:0]             fe_excite_src1_level,
	output logic      [2:0]             fe_excite_src0_level,
	output logic      [1:0]             fe_burnout_level,
	output logic                        fe_ref_pos_buffer_on,
	output logic                        fe_ref_neg_buffer_on,
	output logic      [1:0]             fe_ref_sel,
	output logic      [2:0]             fe_amp_gain_code,
	output logic                        fe_amp_bypass,
	output logic      [2:0]             fe_active_setup,
	output logic                        fe_valid
);
	logic [15:0]            setup_r [ACFG_NUM_SETUPS];
	logic [15:0]            setup_nxt [ACFG_NUM_SETUPS];
	logic                   aw_full_r, aw_full_nxt;
	logic [5:0]             aw_idx_r, aw_idx_nxt;
	logic                   aw_ok_r, aw_ok_nxt;
	logic                   w_full_r, w_full_nxt;
	logic [15:0]            wdata_r, wdata_nxt;
	logic [1:0]             wstrb_r, wstrb_nxt;
	logic                   awready_r, awready_nxt;
	logic                   wready_r, wready_nxt;
	logic                   bvalid_r, bvalid_nxt;
	logic [1:0]             bresp_r, bresp_nxt;
	logic                   arready_r, arready_nxt;
	logic                   rvalid_r, rvalid_nxt;
	logic [1:0]             rresp_r, rresp_nxt;
	logic [ACFG_DATA_W-1:0] rdata_r, rdata_nxt;
	logic [2:0]             exc1_r, exc1_nxt, exc0_r, exc0_nxt;
	logic [1:0]             burn_r, burn_nxt, rsel_r, rsel_nxt;
	logic                   refp_r, refp_nxt, refn_r, refn_nxt;
	logic [2:0]             gain_r, gain_nxt, act_r, act_nxt;
	logic                   byp_r, byp_nxt, fev_r, fev_nxt;
	logic                   do_wr, ar_take;
	logic [5:0]             ar_idx;
	logic [15:0]            sel_word;
	logic [2:0]             d_exc1, d_exc0, d_gain;
	logic [1:0]             d_burn, d_rsel;
	logic                   d_refp, d_refn, d_byp;

	// Word-aligned index of a byte address, and whether it is mapped
	function automatic logic addr_ok(input logic [ACFG_ADDR_W-1:0] a);
		logic [5:0] i;
		i = a[7:2];
		addr_ok = (a[1:0] == 2'h0) &&
			(((i >= ACFG_IDX_SETUP0) && (i <= ACFG_IDX_SETUP7)) || (i == ACFG_IDX_ACTIVE));
	endfunction

	// Setup chosen by the channel about to convert
	assign sel_word = setup_r[conv_setup_sel];

	acfg_setup_fields u_fields (
		.setup_word        (sel_word),
		.excite_src1_level (d_exc1),
		.excite_src0_level (d_exc0),
		.burnout_level     (d_burn),
		.ref_pos_buffer_on (d_refp),
		.ref_neg_buffer_on (d_refn),
		.ref_sel           (d_rsel),
		.amp_gain_code     (d_gain),
		.amp_bypass        (d_byp)
	);

	assign do_wr   = aw_full_r && w_full_r && !bvalid_r;
	assign ar_take = s_axi_arvalid && arready_r;
	assign ar_idx  = s_axi_araddr[7:2];

	always_comb begin
		for (int k = 0; k < ACFG_NUM_SETUPS; k++) begin
			setup_nxt[k] = setup_r[k];
		end
		aw_full_nxt = aw_full_r;
		aw_idx_nxt  = aw_idx_r;
		aw_ok_nxt   = aw_ok_r;
		w_full_nxt  = w_full_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		rvalid_nxt  = rvalid_r;
		rresp_nxt   = rresp_r;
		rdata_nxt   = rdata_r;
		// Address and data are captured independently, in either order
		if (s_axi_awvalid && awready_r) begin
			aw_full_nxt = 1'b1;
			aw_idx_nxt  = s_axi_awaddr[7:2];
			aw_ok_nxt   = addr_ok(s_axi_awaddr);
		end
		if (s_axi_wvalid && wready_r) begin
			w_full_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata[15:0];
			wstrb_nxt  = s_axi_wstrb[1:0];
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (do_wr) begin
			aw_full_nxt = 1'b0;
			w_full_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = aw_ok_r ? ACFG_RESP_OKAY : ACFG_RESP_SLVERR;
			for (int k = 0; k < ACFG_NUM_SETUPS; k++) begin
				if (aw_ok_r && (aw_idx_r == ACFG_IDX_SETUP0 + 6'(k))) begin
					if (wstrb_r[0]) begin
						setup_nxt[k][7:0] = wdata_r[7:0];
					end
					if (wstrb_r[1]) begin
						setup_nxt[k][15:8] = wdata_r[15:8];
					end
				end
			end
		end
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (ar_take) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = '0;
			rresp_nxt  = addr_ok(s_axi_araddr) ? ACFG_RESP_OKAY : ACFG_RESP_SLVERR;
			for (int k = 0; k < ACFG_NUM_SETUPS; k++) begin
				if (ar_idx == ACFG_IDX_SETUP0 + 6'(k)) begin
					rdata_nxt[15:0] = setup_r[k];
				end
			end
			if (ar_idx == ACFG_IDX_ACTIVE) begin
				rdata_nxt[ACFG_ACT_SEL_MSB:0] = act_r;
				rdata_nxt[ACFG_ACT_VALID]     = fev_r;
			end
			if (!addr_ok(s_axi_araddr)) begin
				rdata_nxt = '0;
			end
		end
		awready_nxt = !aw_full_nxt;
		wready_nxt  = !w_full_nxt;
		arready_nxt = !rvalid_nxt;
	end

	// Front-end latch: fields only change when a conversion starts
	always_comb begin
		exc1_nxt = exc1_r;
		exc0_nxt = exc0_r;
		burn_nxt = burn_r;
		refp_nxt = refp_r;
		refn_nxt = refn_r;
		rsel_nxt = rsel_r;
		gain_nxt = gain_r;
		byp_nxt  = byp_r;
		act_nxt  = act_r;
		fev_nxt  = fev_r;
		if (conv_start) begin
			exc1_nxt = d_exc1;
			exc0_nxt = d_exc0;
			burn_nxt = d_burn;
			refp_nxt = d_refp;
			refn_nxt = d_refn;
			rsel_nxt = d_rsel;
			gain_nxt = d_gain;
			byp_nxt  = d_byp;
			act_nxt  = conv_setup_sel;
			fev_nxt  = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int k = 0; k < ACFG_NUM_SETUPS; k++) begin
				setup_r[k] <= ACFG_SETUP_RST;
			end
			aw_full_r <= 1'b0;
			aw_idx_r  <= '0;
			aw_ok_r   <= 1'b0;
			w_full_r  <= 1'b0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= ACFG_RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= ACFG_RESP_OKAY;
			rdata_r   <= '0;
			exc1_r    <= '0;
			exc0_r    <= '0;
			burn_r    <= '0;
			refp_r    <= 1'b0;
			refn_r    <= 1'b0;
			rsel_r    <= '0;
			gain_r    <= '0;
			byp_r     <= 1'b0;
			act_r     <= '0;
			fev_r     <= 1'b0;
		end else begin
			setup_r   <= setup_nxt;
			aw_full_r <= aw_full_nxt;
			aw_idx_r  <= aw_idx_nxt;
			aw_ok_r   <= aw_ok_nxt;
			w_full_r  <= w_full_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
			exc1_r    <= exc1_nxt;
			exc0_r    <= exc0_nxt;
			burn_r    <= burn_nxt;
			refp_r    <= refp_nxt;
			refn_r    <= refn_nxt;
			rsel_r    <= rsel_nxt;
			gain_r    <= gain_nxt;
			byp_r     <= byp_nxt;
			act_r     <= act_nxt;
			fev_r     <= fev_nxt;
		end
	end

	assign s_axi_awready        = awready_r;
	assign s_axi_wready         = wready_r;
	assign s_axi_bvalid         = bvalid_r;
	assign s_axi_bresp          = bresp_r;
	assign s_axi_arready        = arready_r;
	assign s_axi_rvalid         = rvalid_r;
	assign s_axi_rresp          = rresp_r;
	assign s_axi_rdata          = rdata_r;
	assign fe_excite_src1_level = exc1_r;
	assign fe_excite_src0_level = exc0_r;
	assign fe_burnout_level     = burn_r;
	assign fe_ref_pos_buffer_on = refp_r;
	assign fe_ref_neg_buffer_on = refn_r;
	assign fe_ref_sel           = rsel_r;
	assign fe_amp_gain_code     = gain_r;
	assign fe_amp_bypass        = byp_r;
	assign fe_active_setup      = act_r;
	assign fe_valid             = fev_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	reset_zero_a: assert property ($rose(aresetn) |-> setup_r[7] == ACFG_SETUP_RST)
		else $error("setup register not zero after reset");
	write_store_a: assert property (do_wr && aw_ok_r && aw_idx_r == ACFG_IDX_SETUP0
		&& wstrb_r == 2'h3 |=> setup_r[0] == $past(wdata_r))
		else $error("full write to first setup not stored");
	sel_route_a: assert property (conv_start |=> fe_active_setup == $past(conv_setup_sel)
		&& fe_valid)
		else $error("active setup index not latched");
	src1_route_a: assert property (conv_start |=> fe_excite_src1_level
		== $past(sel_word[ACFG_EXC1_MSB:ACFG_EXC1_LSB]))
		else $error("source one level not routed");
	src0_route_a: assert property (conv_start |=> fe_excite_src0_level
		== $past(sel_word[ACFG_EXC0_MSB:ACFG_EXC0_LSB]))
		else $error("source zero level not routed");
	burnout_route_a: assert property (conv_start |=> fe_burnout_level
		== $past(sel_word[ACFG_BURN_MSB:ACFG_BURN_LSB]))
		else $error("burnout level not routed");
	refp_route_a: assert property (conv_start |=> fe_ref_pos_buffer_on
		== $past(sel_word[ACFG_REFP_BIT]))
		else $error("positive buffer not routed");
	refn_route_a: assert property (conv_start |=> fe_ref_neg_buffer_on
		== $past(sel_word[ACFG_REFN_BIT]))
		else $error("negative buffer not routed");
	ref_route_a: assert property (conv_start |=> fe_ref_sel
		== $past(sel_word[ACFG_REFSEL_MSB:ACFG_REFSEL_LSB]))
		else $error("reference select not routed");
	gain_route_a: assert property (conv_start && !sel_word[ACFG_BYP_BIT] |=> fe_amp_gain_code
		== $past(sel_word[ACFG_GAIN_MSB:ACFG_GAIN_LSB]) && !fe_amp_bypass)
		else $error("gain code not routed");
	bypass_gain_a: assert property (fe_amp_bypass |-> fe_amp_gain_code == ACFG_GAIN_UNITY)
		else $error("gain not unity under bypass");
	hold_fields_a: assert property (!conv_start |=> $stable(fe_excite_src1_level)
		&& $stable(fe_amp_gain_code) && $stable(fe_ref_sel) && $stable(fe_active_setup))
		else $error("front-end fields changed without a start");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp))
		else $error("write response dropped");

	write_ok_c: cover property (s_axi_bvalid && s_axi_bresp == ACFG_RESP_OKAY);
	write_err_c: cover property (s_axi_bvalid && s_axi_bresp == ACFG_RESP_SLVERR);
	bypass_start_c: cover property (conv_start && sel_word[ACFG_BYP_BIT]);
	read_setup_c: cover property (s_axi_rvalid && s_axi_rdata != '0);
endmodule

// File: verification/adc_setup_config_bank_test.sv
// Self-checking bench for the setup configuration bank
`timescale 1ns/1ps
module adc_setup_config_bank_test;
	import acfg_pkg::*;

	logic                   aclk;
	logic                   aresetn;
	logic [ACFG_ADDR_W-1:0] s_axi_awaddr;
	logic                   s_axi_awvalid;
	logic                   s_axi_awready;
	logic [ACFG_DATA_W-1:0] s_axi_wdata;
	logic [3:0]             s_axi_wstrb;
	logic                   s_axi_wvalid;
	logic                   s_axi_wready;
	logic [1:0]             s_axi_bresp;
	logic                   s_axi_bvalid;
	logic                   s_axi_bready;
	logic [ACFG_ADDR_W-1:0] s_axi_araddr;
	logic                   s_axi_arvalid;
	logic                   s_axi_arready;
	logic [ACFG_DATA_W-1:0] s_axi_rdata;
	logic [1:0]             s_axi_rresp;
	logic                   s_axi_rvalid;
	logic                   s_axi_rready;
	logic                   conv_start;
	logic [2:0]             conv_setup_sel;
	logic [2:0]             fe_excite_src1_level;
	logic [2:0]             fe_excite_src0_level;
	logic [1:0]             fe_burnout_level;
	logic                   fe_ref_pos_buffer_on;
	logic                   fe_ref_neg_buffer_on;
	logic [1:0]             fe_ref_sel;
	logic [2:0]             fe_amp_gain_code;
	logic                   fe_amp_bypass;
	logic [2:0]             fe_active_setup;
	logic                   fe_valid;
	logic [15:0]            fe_word;
	logic [31:0]            rd_data;
	logic [1:0]             resp;
	int                     failures;
	int                     total_checks;
	int                     cycles;
	int                     b_lag;

	assign fe_word = {fe_excite_src1_level, fe_excite_src0_level, fe_burnout_level,
		fe_ref_pos_buffer_on, fe_ref_neg_buffer_on, fe_ref_sel, fe_amp_gain_code, fe_amp_bypass};

	acfg_bank DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .conv_start(conv_start), .conv_setup_sel(conv_setup_sel),
		.fe_excite_src1_level(fe_excite_src1_level), .fe_excite_src0_level(fe_excite_src0_level),
		.fe_burnout_level(fe_burnout_level), .fe_ref_pos_buffer_on(fe_ref_pos_buffer_on),
		.fe_ref_neg_buffer_on(fe_ref_neg_buffer_on), .fe_ref_sel(fe_ref_sel),
		.fe_amp_gain_code(fe_amp_gain_code), .fe_amp_bypass(fe_amp_bypass),
		.fe_active_setup(fe_active_setup), .fe_valid(fe_valid));

	always #5 aclk = ~aclk;

	task automatic tally_and_finish();
		$display("Checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Hang guard, run needs well under a thousand cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [7:0] sa(input int n);
		return {ACFG_IDX_SETUP0 + 6'(n), 2'b00};
	endfunction

	// Distinct word per setup covering every field code
	function automatic logic [15:0] pat(input int n);
		logic [2:0] k;
		k = 3'(n);
		return {k, ~k, k[1:0], k[0], k[1], k[2:1], k, 1'(n == 3)};
	endfunction

	// Front-end view: gain forced to unity while bypassed
	function automatic logic [15:0] fe_exp(input logic [15:0] w);
		return w[0] ? {w[15:4], ACFG_GAIN_UNITY, 1'b1} : w;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (b_lag == 0);
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				aw_ok = 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				w_ok = 1'b1;
			end
			// Late bready keeps the response waiting for a few cycles
			if (aw_ok && w_ok && !s_axi_bready) begin
				if (b_lag > 0) begin
					b_lag--;
				end else begin
					s_axi_bready <= 1'b1;
				end
			end
			if (aw_ok && w_ok && s_axi_bready && s_axi_bvalid === 1'b1) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) begin
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid === 1'b1) begin
				rd_data = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic conv(input logic [2:0] s);
		@(posedge aclk);
		conv_start <= 1'b1;
		conv_setup_sel <= s;
		@(posedge aclk);
		conv_start <= 1'b0;
		@(negedge aclk);
	endtask

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, conv_start, conv_setup_sel} = '0;
		failures = 0;
		total_checks = 0;
		cycles = 0;
		b_lag = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("fe_valid", fe_valid, 1'h0);
		for (int n = 0; n < 8; n++) begin
			rd(sa(n));
			chk("reset word", rd_data, ACFG_SETUP_RST);
			chk("rresp", resp, ACFG_RESP_OKAY);
		end
		for (int n = 0; n < 8; n++) begin
			wr(sa(n), {16'hffff, pat(n)}, 4'hf);
			chk("bresp", resp, ACFG_RESP_OKAY);
		end
		for (int n = 0; n < 8; n++) begin
			rd(sa(n));
			chk("readback", rd_data, {16'h0000, pat(n)});
		end
		for (int n = 0; n < 8; n++) begin
			conv(3'(n));
			chk("fe fields", fe_word, fe_exp(pat(n)));
			chk("fe_active_setup", fe_active_setup, n);
		end
		// Rewrite during a conversion must not disturb the front end
		conv(3'h2);
		wr(sa(2), 32'h0000_e5b1, 4'hf);
		@(negedge aclk);
		chk("fe held", fe_word, fe_exp(pat(2)));
		conv(3'h2);
		chk("fe new", fe_word, {16'he5b0} | 16'h0001);
		wr(sa(5), 32'h0000_000f, 4'hf);
		conv(3'h5);
		chk("bypassed gain", fe_amp_gain_code, ACFG_GAIN_UNITY);
		rd(sa(5));
		chk("stored gain", rd_data, 32'h0000_000f);
		wr(sa(5), 32'h0000_000e, 4'hf);
		conv(3'h5);
		chk("gain 128", fe_word, 16'h000e);
		// Back-to-back starts
		@(posedge aclk);
		conv_start <= 1'b1;
		conv_setup_sel <= 3'h4;
		@(posedge aclk);
		conv_setup_sel <= 3'h6;
		@(negedge aclk);
		chk("first start", fe_active_setup, 3'h4);
		@(posedge aclk);
		conv_start <= 1'b0;
		@(negedge aclk);
		chk("second start", fe_word, fe_exp(pat(6)));
		rd({ACFG_IDX_ACTIVE, 2'b00});
		chk("status", rd_data, 32'h0000_0106);
		wr({ACFG_IDX_ACTIVE, 2'b00}, 32'h0000_0000, 4'hf);
		chk("status bresp", resp, ACFG_RESP_OKAY);
		// Byte lanes
		wr(sa(0), 32'h0000_a5c3, 4'hf);
		wr(sa(0), 32'h0000_1234, 4'h1);
		rd(sa(0));
		chk("lane 0", rd_data, 32'h0000_a534);
		wr(sa(0), 32'h0000_5600, 4'h2);
		rd(sa(0));
		chk("lane 1", rd_data, 32'h0000_5634);
		// Response held while the master withholds bready
		b_lag = 3;
		wr(sa(1), 32'h0000_7e81, 4'hf);
		chk("late bready", resp, ACFG_RESP_OKAY);
		rd(sa(1));
		chk("late write", rd_data, 32'h0000_7e81);
		// Addresses outside the bank, and a misaligned one inside it
		rd(8'h60);
		chk("below bank", {rd_data[29:0], resp}, {30'h0, ACFG_RESP_SLVERR});
		wr(8'h84, 32'h0000_ffff, 4'hf);
		chk("above bank", resp, ACFG_RESP_SLVERR);
		wr(8'h66, 32'h0000_ffff, 4'hf);
		chk("misaligned", resp, ACFG_RESP_SLVERR);
		rd(sa(0));
		chk("untouched", rd_data, 32'h0000_5634);
		// Reset in mid-run
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("fe_valid again", fe_valid, 1'h0);
		rd(sa(7));
		chk("reset again", rd_data, ACFG_SETUP_RST);
		tally_and_finish();
	end
endmodule
